/* File: hw/part_consts.svh */
`ifndef PART_CONSTS_SVH
`define PART_CONSTS_SVH
// Register indices; byte address is four times the index
`define PART_IDX_DUTY3 8'h73
`define PART_IDX_DUTY2 8'h74
`define PART_IDX_DUTY1 8'h75
`define PART_IDX_DUTY0 8'h76
`define PART_IDX_PWMCTL 8'h77
`define PART_IDX_CSR 8'h78
`define PART_IDX_CNT 8'h79
`define PART_IDX_RELOAD 8'h7A
`define PART_IDX_CAPCSR 8'h7B
`define PART_IDX_CAP1 8'h7C
`define PART_IDX_CAP2 8'h7D
// Control/status field positions
`define PART_CSR_EXT_BIT 7
`define PART_CSR_DIV_HI 6
`define PART_CSR_DIV_LO 4
`define PART_CSR_EN_BIT 3
`define PART_CSR_FRL_BIT 2
`define PART_CSR_OIE_BIT 1
`define PART_CSR_OVF_BIT 0
// Capture control field positions
`define PART_CAP_EDGE_LO 4
`define PART_CAP_IE_LO 2
`define PART_CAP_FLAG_LO 0
// Reset value of every register
`define PART_REG_RESET 8'h00
// Answer for unmapped reads
`define PART_UNMAPPED 32'h00000000
`endif

/* File: hw/part_pkg.sv */
package part_pkg;
  // Decoded register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic [7:0] data;
  } part_req_t;
  // Per-channel PWM control
  typedef struct packed {
    logic [3:0] enables;
    logic [3:0] pwm_polarities;
  } part_pwmctl_t;
  // Bus slave phase
  typedef enum logic {PART_IDLE, PART_DONE} part_bus_t;
endpackage : part_pkg

/* File: hw/part_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "part_consts.svh"
module part_timer #(
  parameter int CAP_CH = 2,
  parameter int PWM_CH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_clk_in,
  input wire logic [CAP_CH-1:0] capture_input_pins,
  output logic [PWM_CH-1:0] pwm_output_pins,
  output logic [PWM_CH-1:0] pwm_oe_n,
  output logic irq
);
  // Register state
  // Duty words are what software sees; the compare copies are what the
  // comparators use, so a half-written duty change never reaches a pin
  logic [7:0] duty_r [PWM_CH];
  logic [7:0] cmp_r [PWM_CH];
  part_pkg::part_pwmctl_t pwmctl_r;
  logic ext_sel_r;
  logic [2:0] div_r;
  logic count_enable_r;
  logic oie_r;
  logic overflow_flag_r;
  logic [7:0] counter_r;
  logic [7:0] reload_r;
  logic [CAP_CH-1:0] edge_r;
  logic [CAP_CH-1:0] cap_ie_r;
  logic [CAP_CH-1:0] capture_flags_r;
  logic [7:0] cap_r [CAP_CH];
  // Prescaler keeps its low bits between stop and start, so a paused
  // count resumes mid tap rather than from zero
  logic [6:0] presc_r;
  // Bus phase, so one held request is served once only
  part_pkg::part_bus_t bus_r;
  part_pkg::part_req_t req;
  logic acc;
  // Pin synchroniser stages and the level last agreed by stages two and three;
  // the agreed level is the reference for edge detection
  logic ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r;
  logic [CAP_CH-1:0] cap_s1_r, cap_s2_r, cap_s3_r, cap_lvl_r;
  logic [6:0] presc_nxt;
  logic tick;
  logic ovf;
  logic wr_csr, wr_cnt, rd_csr, force_reload;
  logic [CAP_CH-1:0] cap_rd;
  logic [CAP_CH-1:0] cap_evt;
  logic [7:0] rdata;

  // Request decode; byte lane 0 carries all 8-bit data
  // Only the first cycle of a request counts; the answer cycle that follows
  // must not repeat a side effect such as a flag clear
  always_comb begin
    acc = (avs_read | avs_write) && (bus_r == part_pkg::PART_IDLE);
    req.rd = acc && avs_read;
    req.wr = acc && avs_write && avs_byteenable[0];
    req.idx = avs_address;
    req.data = avs_writedata[7:0];
  end

  // Strobes for registers with side effects
  // A read strobe here is what clears a flag, so any read slip would lose events
  assign wr_csr = req.wr && (req.idx == `PART_IDX_CSR);
  assign wr_cnt = req.wr && (req.idx == `PART_IDX_CNT);
  assign rd_csr = req.rd && (req.idx == `PART_IDX_CSR);
  assign force_reload = wr_csr && req.data[`PART_CSR_FRL_BIT];
  assign cap_rd[0] = req.rd && (req.idx == `PART_IDX_CAP1);
  assign cap_rd[1] = req.rd && (req.idx == `PART_IDX_CAP2);

  // Bus slave: one wait cycle, answer on the second edge
  // Fixed latency keeps the master simple; there is no back pressure
  // from the timer core, so a longer wait would buy nothing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_r <= part_pkg::PART_IDLE;
    end else begin
      unique case (bus_r)
        part_pkg::PART_IDLE: begin
          if (avs_read | avs_write) begin
            bus_r <= part_pkg::PART_DONE;
          end
        end
        part_pkg::PART_DONE: begin
          bus_r <= part_pkg::PART_IDLE;
        end
      endcase
    end
  end

  // Waitrequest low only in the answer cycle
  // Held high in reset so no transfer can complete before the core is ready
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !acc;
    end
  end

  // Read mux, registered so data stand with waitrequest low
  always_comb begin
    rdata = 8'h00;
    case (req.idx)
      `PART_IDX_DUTY3: rdata = duty_r[3];
      `PART_IDX_DUTY2: rdata = duty_r[2];
      `PART_IDX_DUTY1: rdata = duty_r[1];
      `PART_IDX_DUTY0: rdata = duty_r[0];
      `PART_IDX_PWMCTL: rdata = pwmctl_r;
      // Force-reload slot reads zero
      `PART_IDX_CSR: rdata = {ext_sel_r, div_r, count_enable_r, 1'b0, oie_r, overflow_flag_r};
      `PART_IDX_CNT: rdata = counter_r;
      `PART_IDX_RELOAD: rdata = reload_r;
      `PART_IDX_CAPCSR: rdata = {2'b00, edge_r, cap_ie_r, capture_flags_r};
      `PART_IDX_CAP1: rdata = cap_r[0];
      `PART_IDX_CAP2: rdata = cap_r[1];
      default: rdata = 8'h00;
    endcase
  end

  // Read data latched with the request, so it already stands when
  // waitrequest drops; it then holds until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= `PART_UNMAPPED;
    end else if (req.rd) begin
      avs_readdata <= {24'h000000, rdata};
    end
  end

  // Pin synchronisers: change taken when stages two and three agree
  // Stage one may go metastable and is read by stage two only;
  // the agreement test also drops single-cycle pin glitches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_lvl_r <= 1'b0;
      cap_s1_r <= '0;
      cap_s2_r <= '0;
      cap_s3_r <= '0;
      cap_lvl_r <= '0;
    end else begin
      ext_s1_r <= ext_clk_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_lvl_r <= ext_s3_r;
      end
      cap_s1_r <= capture_input_pins;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      for (int i = 0; i < CAP_CH; i++) begin
        if (cap_s2_r[i] == cap_s3_r[i]) begin
          cap_lvl_r[i] <= cap_s3_r[i];
        end
      end
    end
  end

  // Prescaler input: every CPU clock, or each external rising edge
  // External pulse is one clk wide; the pin must stay below clk/4,
  // otherwise edges merge in the synchroniser and counts are lost
  logic presc_in;
  assign presc_in = ext_sel_r ? (ext_s2_r && ext_s3_r && !ext_lvl_r) : 1'b1;
  assign presc_nxt = presc_r + 7'h01;
  // Tap selects divide by 2^n; tap 0 passes every input pulse
  always_comb begin
    tick = 1'b0;
    if (count_enable_r && presc_in) begin
      if (div_r == 3'h0) begin
        tick = 1'b1;
      end else begin
        tick = (presc_nxt & ((7'h01 << div_r) - 7'h01)) == 7'h00;
      end
    end
  end
  // Overflow is the tick that leaves FFh; it drives reload, flag and compare copy
  assign ovf = tick && (counter_r == 8'hFF);

  // Prescaler; cleared on force reload or counter write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_r <= 7'h00;
    end else if (force_reload || wr_cnt) begin
      presc_r <= 7'h00;
    end else if (count_enable_r && presc_in) begin
      presc_r <= presc_nxt;
    end
  end

  // Counter: write, force reload, overflow reload, count
  // A software write wins over a coinciding overflow; the flag still
  // records that overflow in its own process
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_r <= `PART_REG_RESET;
    end else if (wr_cnt) begin
      counter_r <= req.data;
    end else if (force_reload) begin
      counter_r <= reload_r;
    end else if (ovf) begin
      counter_r <= reload_r;
    end else if (tick) begin
      counter_r <= counter_r + 8'h01;
    end
  end

  // Control/status; hardware set beats read clear
  // Force reload is a strobe only and keeps no state, hence it reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sel_r <= 1'b0;
      div_r <= 3'h0;
      count_enable_r <= 1'b0;
      oie_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end else begin
      if (wr_csr) begin
        ext_sel_r <= req.data[`PART_CSR_EXT_BIT];
        div_r <= req.data[`PART_CSR_DIV_HI:`PART_CSR_DIV_LO];
        count_enable_r <= req.data[`PART_CSR_EN_BIT];
        oie_r <= req.data[`PART_CSR_OIE_BIT];
      end
      if (ovf) begin
        overflow_flag_r <= 1'b1;
      end else if (rd_csr) begin
        overflow_flag_r <= 1'b0;
      end
    end
  end

  // Software registers: duty, PWM control, reload, capture control
  // Writes to capture values and unmapped slots fall to the default item
  // A new reload value is used only at the next overflow or force reload
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PWM_CH; i++) begin
        duty_r[i] <= `PART_REG_RESET;
      end
      pwmctl_r <= `PART_REG_RESET;
      reload_r <= `PART_REG_RESET;
      edge_r <= '0;
      cap_ie_r <= '0;
    end else if (req.wr) begin
      case (req.idx)
        `PART_IDX_DUTY3: duty_r[3] <= req.data;
        `PART_IDX_DUTY2: duty_r[2] <= req.data;
        `PART_IDX_DUTY1: duty_r[1] <= req.data;
        `PART_IDX_DUTY0: duty_r[0] <= req.data;
        `PART_IDX_PWMCTL: pwmctl_r <= req.data;
        `PART_IDX_RELOAD: reload_r <= req.data;
        `PART_IDX_CAPCSR: begin
          edge_r <= req.data[`PART_CAP_EDGE_LO +: 2];
          cap_ie_r <= req.data[`PART_CAP_IE_LO +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // Hidden compare registers load only at overflow
  // Limitation: a duty written while stopped waits for the first overflow
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PWM_CH; i++) begin
        cmp_r[i] <= `PART_REG_RESET;
      end
    end else if (ovf) begin
      for (int i = 0; i < PWM_CH; i++) begin
        cmp_r[i] <= duty_r[i];
      end
    end
  end

  // PWM outputs: level from count vs compare, xor polarity, so a polarity
  // change flips the pin on the next edge; counter reload at overflow
  // makes the level switch together with the period start
  genvar g;
  generate
    for (g = 0; g < PWM_CH; g++) begin : g_pwm
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pwm_output_pins[g] <= 1'b0;
          pwm_oe_n[g] <= 1'b1;
        end else begin
          pwm_output_pins[g] <= (counter_r <= cmp_r[g]) ^ pwmctl_r.pwm_polarities[g];
          pwm_oe_n[g] <= !pwmctl_r.enables[g];
        end
      end
    end
  endgenerate

  // Capture: edge per sensitivity; blocked while flag set
  // An edge that arrives while the flag is set is dropped, not queued;
  // software must read the value before the next edge to keep up
  generate
    for (g = 0; g < CAP_CH; g++) begin : g_cap
      assign cap_evt[g] = (cap_s2_r[g] == cap_s3_r[g]) && (cap_s3_r[g] != cap_lvl_r[g])
                          && (cap_s3_r[g] == edge_r[g]);
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cap_r[g] <= `PART_REG_RESET;
          capture_flags_r[g] <= 1'b0;
        end else begin
          if (cap_evt[g] && !capture_flags_r[g]) begin
            cap_r[g] <= counter_r;
          end
          if (cap_evt[g] && !capture_flags_r[g]) begin
            capture_flags_r[g] <= 1'b1;
          end else if (cap_rd[g]) begin
            capture_flags_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Interrupt request follows the enabled flags
  // Level output: it stays high until every enabled flag is cleared,
  // so a missed edge at the interrupt controller cannot lose a request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (overflow_flag_r && oie_r) || |(capture_flags_r & cap_ie_r);
    end
  end
endmodule : part_timer
`default_nettype wire

/* File: tb/part_timer_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module part_timer_checker #(
  parameter int CAP_CH = 2,
  parameter int PWM_CH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ext_clk_in,
  input wire logic [CAP_CH-1:0] capture_input_pins,
  input wire logic [PWM_CH-1:0] pwm_output_pins,
  input wire logic [PWM_CH-1:0] pwm_oe_n,
  input wire logic irq
);
  logic [2:0] en_r;
  logic wr_ok;
  logic rd_ok;
  // Accepted transfers, seen at the answer edge
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // Shadow of the interrupt enables, so masking can be judged without the body
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= 3'h0;
    end else if (wr_ok && avs_address == 8'h78) begin
      en_r[0] <= avs_writedata[1];
    end else if (wr_ok && avs_address == 8'h7B) begin
      en_r[2:1] <= avs_writedata[3:2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered in time");
  AST_UPPER_ZERO: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_FRL_READ: assert property (rd_ok && avs_address == 8'h78 |-> !avs_readdata[2])
    else $error("force reload bit read as one");
  AST_RSVD: assert property (rd_ok && avs_address == 8'h7B |-> avs_readdata[7:6] == 2'h0)
    else $error("reserved capture bits not zero");
  AST_OE_MAP: assert property (wr_ok && avs_address == 8'h77 |=> ##1 pwm_oe_n == ~$past(avs_writedata[7:4], 2))
    else $error("output enables do not follow control write");
  AST_IRQ_QUIET: assert property ((en_r == 3'h0) [*3] |-> !irq)
    else $error("interrupt raised with all enables off");
  AST_RST_OUT: assert property ($rose(reset_n) |-> pwm_oe_n == 4'hF && !irq && pwm_output_pins == 4'h0)
    else $error("outputs not at reset state");
  // Main scenarios reached
  cover property (rd_ok && avs_address == 8'h78 && avs_readdata[0]);
  cover property ($rose(irq));
  cover property (rd_ok && avs_address == 8'h7C);
endmodule : part_timer_checker
bind part_timer part_timer_checker #(.CAP_CH(CAP_CH), .PWM_CH(PWM_CH)) part_timer_checker_i (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clk_in(ext_clk_in),
  .capture_input_pins(capture_input_pins), .pwm_output_pins(pwm_output_pins),
  .pwm_oe_n(pwm_oe_n), .irq(irq));
`default_nettype wire

/* File: tb/part_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module part_far_model (
  input wire logic clk,
  output logic ext_clk_in,
  output logic [1:0] capture_input_pins,
  input wire logic [3:0] pwm_output_pins
);
  initial ext_clk_in = 1'b0;
  initial capture_input_pins = 2'b00;
  // External events, eight cycles a period: well below the clk/4 limit
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      ext_clk_in <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk_in <= 1'b0;
    end
  endtask : ext_pulses
  // Move one capture line, then allow for the input synchroniser
  task automatic cap_to(input int ch, input logic lvl);
    @(posedge clk);
    capture_input_pins[ch] <= lvl;
    repeat (8) @(posedge clk);
  endtask : cap_to
endmodule : part_far_model
`default_nettype wire

/* File: tb/part_timer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module part_timer_tb;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ext_clk_in, irq, wq;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF, pins, oe_n;
  logic [1:0] cap;
  logic [7:0] q;
  int n_fail = 0, compares = 0, cyc = 0, t1, ones[3];
  part_timer part_timer_i (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(wq),
    .ext_clk_in(ext_clk_in), .capture_input_pins(cap), .pwm_output_pins(pins),
    .pwm_oe_n(oe_n), .irq(irq));
  part_far_model part_far_model_i (.clk(clk), .ext_clk_in(ext_clk_in),
    .capture_input_pins(cap), .pwm_output_pins(pins));
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    i = 0;
    do begin @(posedge clk); i++; end while (wq !== 1'b0 && i < 50);
    q = avs_readdata[7:0];
    if (i >= 50) begin n_fail++; end_of_test(); end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e); bus(1'b0, a, 8'h00); chk(q, e); endtask : rdc
  task automatic wait_irq(input logic lvl);
    int i;
    i = 0;
    while (irq !== lvl && i < 2000) begin @(posedge clk); i++; end
    if (i >= 2000) begin n_fail++; end_of_test(); end
  endtask : wait_irq
  task automatic regs_rw;
    for (int a = 8'h73; a <= 8'h7A; a++) if (a != 8'h78) wr(a[7:0], 8'hA5);
    for (int a = 8'h73; a <= 8'h7A; a++) if (a != 8'h78) rdc(a[7:0], 8'hA5);
    wr(8'h7C, 8'hFF);
    rdc(8'h7C, 8'h00);
    wr(8'h7B, 8'hFF);
    rdc(8'h7B, 8'h3C);
    wr(8'h78, 8'h76);
    rdc(8'h78, 8'h72);
    wr(8'h78, 8'h00);
    wr(8'h7B, 8'h00);
  endtask : regs_rw
  // Counter stopped at zero, compare still zero from reset
  task automatic polarity;
    wr(8'h79, 8'h00);
    wr(8'h77, 8'hF0);
    repeat (2) @(posedge clk);
    chk({oe_n, pins}, 8'h0F);
    wr(8'h77, 8'hF5);
    repeat (2) @(posedge clk);
    chk(pins, 4'hA);
  endtask : polarity
  task automatic period_duty;
    wr(8'h7A, 8'hF0);
    wr(8'h76, 8'hF8);
    wr(8'h75, 8'hEF);
    wr(8'h74, 8'hF8);
    wr(8'h77, 8'hF4);
    for (int n = 0; n < 4; n++) begin
      wr(8'h78, {1'b0, n[2:0], 4'hE});
      bus(1'b0, 8'h78, 8'h00);
      wait_irq(1'b0);
      wait_irq(1'b1);
      t1 = cyc;
      rdc(8'h78, {1'b0, n[2:0], 4'hB});
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk(cyc - t1, 16 << n);
    end
    ones = '{0, 0, 0};
    repeat (128) begin
      @(posedge clk);
      for (int c = 0; c < 3; c++) ones[c] += pins[c];
    end
    chk(ones[0], 72);
    chk(ones[1], 0);
    chk(ones[2], 56);
    chk(pins[3], 1'b0);
  endtask : period_duty
  task automatic ext_count;
    wr(8'h7A, 8'hFC);
    wr(8'h78, 8'h8E);
    bus(1'b0, 8'h78, 8'h00);
    part_far_model_i.ext_pulses(3);
    repeat (10) @(posedge clk);
    chk(irq, 1'b0);
    part_far_model_i.ext_pulses(1);
    wait_irq(1'b1);
    rdc(8'h79, 8'hFC);
  endtask : ext_count
  task automatic capture;
    wr(8'h78, 8'h00);
    wr(8'h79, 8'h5A);
    repeat (20) @(posedge clk);
    rdc(8'h79, 8'h5A);
    wr(8'h7B, 8'h14);
    part_far_model_i.cap_to(0, 1'b1);
    chk(irq, 1'b1);
    rdc(8'h7B, 8'h15);
    rdc(8'h7B, 8'h15);
    wr(8'h79, 8'h33);
    part_far_model_i.cap_to(0, 1'b0);
    part_far_model_i.cap_to(0, 1'b1);
    rdc(8'h7C, 8'h5A);
    rdc(8'h7B, 8'h14);
    chk(irq, 1'b0);
    wr(8'h7B, 8'h08);
    part_far_model_i.cap_to(1, 1'b1);
    rdc(8'h7B, 8'h08);
    part_far_model_i.cap_to(1, 1'b0);
    rdc(8'h7B, 8'h0A);
    wr(8'h7D, 8'hFF);
    rdc(8'h7D, 8'h33);
  endtask : capture
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int a = 8'h73; a <= 8'h7D; a++) rdc(a[7:0], 8'h00);
    rdc(8'h50, 8'h00);
    regs_rw();
    polarity();
    period_duty();
    ext_count();
    capture();
    end_of_test();
  end
endmodule : part_timer_tb
`default_nettype wire
